// ==== dts_sequencer.v ====
// Receive-delay tuning sequencer with second-stage recapture of read data.
`include "dts_map.vh"

// How it works
// - Recapture delayed-clock data on the transmit clock.
// - Only phase changes; sample clock frequency untouched.
// - Single-step failures inside window mark retiming points.
// - Coarse pick below forty is accepted directly.
// - Coarse sweep in steps of four, recording results.
// - Pick middle of largest contiguous passing run.
// - Test ten single steps either side of pick.
// - Shift away from nearby errors, else keep pick.
// - Trim final ratio by current temperature.
module dts_sequencer (
    // Clock and reset
    input  wire                       clk_sys_in,
    input  wire                       reset_in,
    // Control
    input  wire                       start_in,
    output wire                       busy_out,
    output reg                        done_out,
    output reg                        fail_out,
    // Trial handshake with the host
    output reg                        trial_req_out,
    output reg  [`DTS_RATIO_W-1:0]    ratio_out,
    input  wire                       trial_done_in,
    input  wire                       trial_pass_in,
    input  wire [`DTS_TEMP_W-1:0]     temp_in,
    // Result applied to the delay line
    output reg  [`DTS_RATIO_W-1:0]    final_ratio_out,
    // Read data path
    input  wire [`DTS_DATA_W-1:0]     rx_stage1_in,
    output reg  [`DTS_DATA_W-1:0]     rx_data_out
);

    localparam [3:0] ST_IDLE     = 4'h0;
    localparam [3:0] ST_C_REQ    = 4'h1;
    localparam [3:0] ST_C_WAIT   = 4'h2;
    localparam [3:0] ST_PICK     = 4'h3;
    localparam [3:0] ST_F_REQ    = 4'h4;
    localparam [3:0] ST_F_WAIT   = 4'h5;
    localparam [3:0] ST_ADJUST   = 4'h6;
    localparam [3:0] ST_TEMP     = 4'h7;

    reg        [3:0]              state;
    reg        [`DTS_RATIO_W-1:0] run_start;
    reg        [5:0]              run_len;
    reg        [`DTS_RATIO_W-1:0] best_start;
    reg        [5:0]              best_len;
    reg        [`DTS_RATIO_W-1:0] chosen;
    reg signed [9:0]              fine_hi;
    reg signed [9:0]              lo_fail;
    reg signed [9:0]              hi_fail;
    reg                           hi_seen;
    reg        [5:0]              next_run_len;
    reg signed [9:0]              mid;

    // Saturate a signed working value onto the legal ratio range.
    function [`DTS_RATIO_W-1:0] clamp_ratio;
        input signed [9:0] v;
        begin
            if (v < 10'sh000) begin
                clamp_ratio = 7'h00;
            end else if (v > $signed({3'h0, `DTS_RATIO_MAX})) begin
                clamp_ratio = `DTS_RATIO_MAX;
            end else begin
                clamp_ratio = v[`DTS_RATIO_W-1:0];
            end
        end
    endfunction

    function signed [9:0] widen;
        input [`DTS_RATIO_W-1:0] r;
        begin
            widen = $signed({3'h0, r});
        end
    endfunction

    // Coarse pick: run start plus four elements for every two passing points.
    function [`DTS_RATIO_W-1:0] coarse_pick;
        input [`DTS_RATIO_W-1:0] base;
        input [5:0]              len;
        begin
            coarse_pick = base + {len[5:1], 2'b00};
        end
    endfunction

    assign busy_out = (state != ST_IDLE);

    // The sample clock is only delayed, never divided, so the transmit clock alone retimes.
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            rx_data_out <= 8'h00;
        end else begin
            rx_data_out <= rx_stage1_in;
        end
    end

    always @* begin
        if (trial_pass_in) begin
            next_run_len = run_len + 6'h01;
        end else begin
            next_run_len = 6'h00;
        end
        mid = (lo_fail + hi_fail) >>> 1;
    end

    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state           <= ST_IDLE;
            done_out        <= 1'b0;
            fail_out        <= 1'b0;
            trial_req_out   <= 1'b0;
            ratio_out       <= 7'h00;
            final_ratio_out <= 7'h00;
            run_start       <= 7'h00;
            run_len         <= 6'h00;
            best_start      <= 7'h00;
            best_len        <= 6'h00;
            chosen          <= 7'h00;
            fine_hi         <= 10'sh000;
            lo_fail         <= 10'sh000;
            hi_fail         <= 10'sh000;
            hi_seen         <= 1'b0;
        end else begin
            done_out      <= 1'b0;
            trial_req_out <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_in) begin
                        fail_out   <= 1'b0;
                        ratio_out  <= 7'h00;
                        run_len    <= 6'h00;
                        best_len   <= 6'h00;
                        best_start <= 7'h00;
                        state      <= ST_C_REQ;
                    end
                end
                ST_C_REQ: begin
                    trial_req_out <= 1'b1;
                    state         <= ST_C_WAIT;
                end
                ST_C_WAIT: begin
                    if (trial_done_in) begin
                        run_len <= next_run_len;
                        if (trial_pass_in && run_len == 6'h00) begin
                            run_start <= ratio_out;
                        end
                        if (next_run_len > best_len) begin
                            best_len <= next_run_len;
                            if (run_len == 6'h00) begin
                                best_start <= ratio_out;
                            end else begin
                                best_start <= run_start;
                            end
                        end
                        if (ratio_out > `DTS_RATIO_MAX - `DTS_COARSE_STEP) begin
                            state <= ST_PICK;
                        end else begin
                            ratio_out <= ratio_out + `DTS_COARSE_STEP;
                            state     <= ST_C_REQ;
                        end
                    end
                end
                ST_PICK: begin
                    if (best_len == 6'h00) begin
                        // No passing point at all; report and leave the old ratio in place.
                        fail_out <= 1'b1;
                        done_out <= 1'b1;
                        state    <= ST_IDLE;
                    end else begin
                        chosen <= coarse_pick(best_start, best_len);
                        if (coarse_pick(best_start, best_len) < `DTS_DIRECT_LIMIT) begin
                            state <= ST_TEMP;
                        end else begin
                            ratio_out <= clamp_ratio(widen(coarse_pick(best_start, best_len))
                                                     - `DTS_FINE_SPAN);
                            fine_hi   <= widen(coarse_pick(best_start, best_len))
                                         + `DTS_FINE_SPAN;
                            lo_fail   <= widen(coarse_pick(best_start, best_len))
                                         - `DTS_NO_FAIL_SPAN;
                            hi_fail   <= widen(coarse_pick(best_start, best_len))
                                         + `DTS_NO_FAIL_SPAN;
                            hi_seen   <= 1'b0;
                            state     <= ST_F_REQ;
                        end
                    end
                end
                ST_F_REQ: begin
                    trial_req_out <= 1'b1;
                    state         <= ST_F_WAIT;
                end
                ST_F_WAIT: begin
                    if (trial_done_in) begin
                        if (!trial_pass_in) begin
                            if (ratio_out <= chosen) begin
                                lo_fail <= widen(ratio_out);
                            end else if (!hi_seen) begin
                                hi_fail <= widen(ratio_out);
                                hi_seen <= 1'b1;
                            end
                        end
                        if (widen(ratio_out) >= fine_hi || ratio_out == `DTS_RATIO_MAX) begin
                            state <= ST_ADJUST;
                        end else begin
                            ratio_out <= ratio_out + 7'h01;
                            state     <= ST_F_REQ;
                        end
                    end
                end
                ST_ADJUST: begin
                    // Centring between the nearest error points gives equal margin to both.
                    if (lo_fail == widen(chosen) - `DTS_NO_FAIL_SPAN && !hi_seen) begin
                        chosen <= chosen;
                    end else begin
                        chosen <= clamp_ratio(mid);
                    end
                    state <= ST_TEMP;
                end
                ST_TEMP: begin
                    // Trims are fixed steps; a finer model would need characterised data.
                    if (temp_in >= `DTS_TEMP_HOT) begin
                        final_ratio_out <= clamp_ratio(widen(chosen) + `DTS_TEMP_HOT_TRIM);
                    end else if (temp_in <= `DTS_TEMP_COLD) begin
                        final_ratio_out <= clamp_ratio(widen(chosen) - `DTS_TEMP_COLD_TRIM);
                    end else begin
                        final_ratio_out <= chosen;
                    end
                    ratio_out <= chosen;
                    done_out  <= 1'b1;
                    state     <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // dts_sequencer

// ==== dts_map.vh ====
// Constants for the delay tuning sequencer: ratio range, step sizes and temperature trims.
`ifndef DTS_MAP_VH
`define DTS_MAP_VH

`define DTS_RATIO_W        7
`define DTS_RATIO_MAX      7'h7f
`define DTS_COARSE_STEP    7'h04
`define DTS_COARSE_POINTS  6'h20
`define DTS_FINE_SPAN      10'sh00a
`define DTS_NO_FAIL_SPAN   10'sh00b
`define DTS_DIRECT_LIMIT   7'h28
`define DTS_TEMP_W         8
`define DTS_TEMP_HOT       8'h55
`define DTS_TEMP_COLD      8'h0a
`define DTS_TEMP_HOT_TRIM  10'sh002
`define DTS_TEMP_COLD_TRIM 10'sh002
`define DTS_DATA_W         8

`endif

// ==== dts_sequencer_props.sv ====
// Port-level assertions for the delay tuning sequencer.
`include "dts_map.vh"
module dts_sequencer_props (
    input wire                    clk_sys_in,
    input wire                    reset_in,
    input wire                    start_in,
    input wire                    busy_out,
    input wire                    done_out,
    input wire                    fail_out,
    input wire                    trial_req_out,
    input wire [`DTS_RATIO_W-1:0] ratio_out,
    input wire                    trial_done_in,
    input wire                    trial_pass_in,
    input wire [`DTS_TEMP_W-1:0]  temp_in,
    input wire [`DTS_RATIO_W-1:0] final_ratio_out,
    input wire [`DTS_DATA_W-1:0]  rx_stage1_in,
    input wire [`DTS_DATA_W-1:0]  rx_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    property p_recap; !$past(reset_in) |-> rx_data_out == $past(rx_stage1_in); endproperty
    a_recap: assert property (p_recap) else $error("recapture wrong");
    property p_hold; trial_req_out |=> $stable(ratio_out); endproperty
    a_hold: assert property (p_hold) else $error("ratio moved in trial");
    property p_first; start_in && !busy_out |=> busy_out ##1 trial_req_out && ratio_out == 0; endproperty
    a_first: assert property (p_first) else $error("sweep start wrong");
    property p_pulse; trial_req_out |=> !trial_req_out; endproperty
    a_pulse: assert property (p_pulse) else $error("request too long");
    property p_busy; trial_req_out |-> busy_out; endproperty
    a_busy: assert property (p_busy) else $error("request while idle");
    property p_done; done_out |-> !busy_out ##1 !done_out; endproperty
    a_done: assert property (p_done) else $error("done malformed");
    property p_keep; done_out && fail_out |-> $stable(final_ratio_out); endproperty
    a_keep: assert property (p_keep) else $error("failed run moved result");
    property p_mild; done_out && !fail_out && $past(temp_in) > `DTS_TEMP_COLD
        && $past(temp_in) < `DTS_TEMP_HOT |-> final_ratio_out == ratio_out; endproperty
    a_mild: assert property (p_mild) else $error("untrimmed result wrong");
    c_ok: cover property (done_out && !fail_out);
    c_fail: cover property (done_out && fail_out);
    c_fine: cover property (trial_req_out && ratio_out[1:0] != 2'h0);
endmodule // dts_sequencer_props
bind dts_sequencer dts_sequencer_props i_props (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .start_in(start_in), .busy_out(busy_out), .done_out(done_out), .fail_out(fail_out),
    .trial_req_out(trial_req_out), .ratio_out(ratio_out), .trial_done_in(trial_done_in),
    .trial_pass_in(trial_pass_in), .temp_in(temp_in), .final_ratio_out(final_ratio_out),
    .rx_stage1_in(rx_stage1_in), .rx_data_out(rx_data_out));

// ==== dts_host_model.sv ====
// Host model answering each tuning trial from a pass map.
module dts_host_model (
    // Clock, reset, trial handshake, pass map, lag and trial count
    input  wire         clk_sys_in,
    input  wire         reset_in,
    input  wire         trial_req_in,
    input  wire [6:0]   ratio_in,
    input  wire [127:0] pass_map_in,
    input  wire [3:0]   lag_in,
    output reg          trial_done_out,
    output reg          trial_pass_out,
    output int          n_trials_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_left;
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            {trial_done_out, trial_pass_out, wait_left} <= 6'h00;
            n_trials_out <= 0;
        end else begin
            trial_done_out <= 1'b0;
            // Junk outside a result pulse, so a stale pass is never read.
            trial_pass_out <= ~trial_pass_out;
            if (trial_req_in) begin
                wait_left <= lag_in;
                n_trials_out <= n_trials_out + 1;
            end else if (wait_left == 4'h1) begin
                trial_done_out <= 1'b1;
                trial_pass_out <= pass_map_in[ratio_in];
                wait_left <= 4'h0;
            end else if (wait_left != 4'h0) begin
                wait_left <= wait_left - 4'h1;
            end
        end
    end
endmodule // dts_host_model

// ==== dts_sequencer_bench.sv ====
// Self-checking bench for the delay tuning sequencer.
`include "dts_map.vh"
module dts_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_sys_in, reset_in, start_in;
    logic [7:0]        temp_in, rx_stage1_in;
    logic [127:0]      pass_map;
    logic [3:0]        lag;
    wire               busy_out, done_out, fail_out, trial_req_out, trial_done_in, trial_pass_in;
    wire  [6:0]        ratio_out, final_ratio_out;
    wire  [7:0]        rx_data_out;
    int                n_trials, t0, cycles = 0, bad_count = 0, n_compared = 0;
    // lo1 hi1 lo2 hi2 hole temp lag final fail trials
    logic [9:0][7:0]   rows [8] = '{80'h081c0100003001140020, 80'h081c0100005503160020,
        80'h081c0100000a02120020, 80'h28640100003001480035, 80'h286401004b3002440035,
        80'h08103038003001_0c0020, 80'h080c3040003001380035, 80'h01000100003001380120};
    dts_sequencer i_dts_sequencer (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .start_in(start_in), .busy_out(busy_out), .done_out(done_out), .fail_out(fail_out),
        .trial_req_out(trial_req_out), .ratio_out(ratio_out), .trial_done_in(trial_done_in),
        .trial_pass_in(trial_pass_in), .temp_in(temp_in), .final_ratio_out(final_ratio_out),
        .rx_stage1_in(rx_stage1_in), .rx_data_out(rx_data_out));
    dts_host_model i_dts_host_model (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .trial_req_in(trial_req_out), .ratio_in(ratio_out), .pass_map_in(pass_map),
        .lag_in(lag), .trial_done_out(trial_done_in), .trial_pass_out(trial_pass_in),
        .n_trials_out(n_trials));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic run(input logic [9:0][7:0] r);
        logic [127:0] m;
        for (int i = 0; i < 128; i++) m[i] = (i >= r[9] && i <= r[8]) || (i >= r[7] && i <= r[6]);
        m[r[5]] = 1'b0;
        @(posedge clk_sys_in);
        pass_map <= m;
        temp_in <= r[4];
        lag <= r[3][3:0];
        start_in <= 1'b1;
        t0 = n_trials;
        @(posedge clk_sys_in);
        start_in <= 1'b0;
        repeat (2000) begin
            @(posedge clk_sys_in);
            #1;
            if (done_out === 1'b1) break;
        end
        check("done", {7'h00, done_out}, 8'h01);
        check("fail", {7'h00, fail_out}, r[1]);
        check("final", {1'b0, final_ratio_out}, r[2]);
        check("trials", 8'(n_trials - t0), r[0]);
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // Whole run is well under a thousand trials; this only stops a hang.
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        {reset_in, start_in, temp_in, rx_stage1_in, pass_map, lag} = {2'h2, 16'h0000, 128'h0, 4'h1};
        repeat (10) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        foreach (rows[k]) run(rows[k]);
        @(posedge clk_sys_in);
        rx_stage1_in <= 8'h5a;
        @(posedge clk_sys_in);
        rx_stage1_in <= 8'ha5;
        #1 check("rx", rx_data_out, 8'h5a);
        @(posedge clk_sys_in);
        start_in <= 1'b1;
        #1 check("rx", rx_data_out, 8'ha5);
        @(posedge clk_sys_in);
        start_in <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        reset_in <= 1'b1;
        @(posedge clk_sys_in);
        reset_in <= 1'b0;
        #1 check("final", {busy_out, final_ratio_out}, 8'h00);
        run(rows[4]);
        wrap_up;
    end
endmodule // dts_sequencer_bench
